//--- verification/cpds_proc_model.sv
`timescale 1ns/1ps
// processor side: debug power handshake and cache reset assistance
module cpds_proc_model (
  input wire logic i_clk, // core clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [3:0] i_ack_delay, // handshake latency in cycles
  input wire logic i_debug_powerdown_request, // from controller
  input wire logic i_power_on_reset_n, // from controller
  input wire logic i_l1d_reset_inhibit, // from controller
  input wire logic i_l2_reset_inhibit, // from controller
  output logic o_debug_powerdown_acknowledge, // to controller
  output logic o_trace_powerdown_acknowledge, // to controller
  output logic [1:0] o_cache_wiped // l2, l1d: hardware reset ran
);
  logic [3:0] cnt;
  logic por_q;
  // trace handshake shares the debug domain, never answered
  assign o_trace_powerdown_acknowledge = 1'b0;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 4'h0;
      por_q <= 1'b1;
      o_debug_powerdown_acknowledge <= 1'b0;
      o_cache_wiped <= 2'h0;
    end else begin
      por_q <= i_power_on_reset_n;
      if (o_debug_powerdown_acknowledge == i_debug_powerdown_request) begin
        cnt <= 4'h0;
      end else if (cnt >= i_ack_delay) begin
        cnt <= 4'h0;
        o_debug_powerdown_acknowledge <= i_debug_powerdown_request;
      end else begin
        cnt <= cnt + 4'h1;
      end
      if (i_power_on_reset_n && !por_q) begin
        o_cache_wiped <= {~i_l2_reset_inhibit, ~i_l1d_reset_inhibit};
      end
    end
  end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cpds_pkg::*;
  logic i_clk, i_resetn, pd, pu, co, rl1, rl2, lz, crel, ack, tack, req, treq;
  logic crst, vrst, por, cclp, vclp, csup, vsup, l1i, l2i, l1c, l2c, rel, busy, e_l1, e_l2;
  logic [3:0] dly;
  logic [1:0] wiped;
  cpds_state_type st;
  int errors, n_compared;
  cpds_sequencer i_cpds_sequencer (.i_clk(i_clk), .i_resetn(i_resetn), .i_power_down(pd),
    .i_power_up(pu), .i_core_only(co), .i_retain_l1d(rl1), .i_retain_l2(rl2),
    .i_l2_zero_size(lz), .i_cache_clamp_release(crel), .i_debug_powerdown_acknowledge(ack),
    .i_trace_powerdown_acknowledge(tack), .o_debug_powerdown_request(req),
    .o_trace_powerdown_request(treq), .o_core_reset_n(crst), .o_vector_unit_reset_n(vrst),
    .o_power_on_reset_n(por), .o_core_output_clamp(cclp), .o_vector_unit_output_clamp(vclp),
    .o_core_supply_on(csup), .o_vector_unit_supply_on(vsup), .o_l1d_reset_inhibit(l1i),
    .o_l2_reset_inhibit(l2i), .o_l1d_ram_clamp(l1c), .o_l2_ram_clamp(l2c),
    .o_cache_clamp_released(rel), .o_busy(busy), .o_state(st));
  cpds_proc_model i_cpds_proc_model (.i_clk(i_clk), .i_resetn(i_resetn), .i_ack_delay(dly),
    .i_debug_powerdown_request(req), .i_power_on_reset_n(por), .i_l1d_reset_inhibit(l1i),
    .i_l2_reset_inhibit(l2i), .o_debug_powerdown_acknowledge(ack),
    .o_trace_powerdown_acknowledge(tack), .o_cache_wiped(wiped));
  always #20 i_clk = ~i_clk;
  task tick;
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wait_state(input cpds_state_type s);
    int n = 0;
    while (st !== s && n < 300) begin
      tick();
      n++;
    end
    chk("state", 1'b1, st === s);
  endtask
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_reset;
    chk("trace request", 1'b0, treq);
    chk("inhibits", 1'b0, l1i | l2i);
    chk("resets idle", 1'b1, crst & vrst & por);
  endtask
  task automatic t_down(input logic a, input logic b, input logic z, input logic [3:0] d);
    int n = 0;
    @(posedge i_clk);
    dly <= d;
    rl1 <= a;
    rl2 <= b;
    lz <= z;
    pd <= 1'b1;
    e_l2 = b;
    e_l1 = a & (b | z);
    @(posedge i_clk);
    pd <= 1'b0;
    #1;
    while (req !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk("request", 1'b1, req);
    repeat (d) tick();
    chk("reset before ack", 1'b1, crst);
    wait_state(CPDS_HOLD_RESET);
    chk("busy", 1'b1, busy);
    chk("l2 inhibit", e_l2, l2i);
    chk("l1d inhibit", e_l1, l1i);
    n = 0;
    while (cclp !== 1'b1 && n < 40) begin
      chk("resets held", 1'b0, crst | vrst | por);
      tick();
      n++;
    end
    chk("hold length", 1'b1, n >= RESET_HOLD_CYCLES);
    chk("vector clamp", 1'b1, vclp);
    wait_state(CPDS_OFF);
    chk("supplies", 1'b0, csup | vsup);
    chk("clamps", 1'b1, cclp & vclp);
    chk("resets off", 1'b0, crst | vrst | por);
    chk("l2 ram clamp", e_l2, l2c);
    chk("l1d ram clamp", e_l1, l1c);
  endtask
  task automatic t_up(input logic c);
    int n = 0;
    @(posedge i_clk);
    co <= c;
    pu <= 1'b1;
    @(posedge i_clk);
    pu <= 1'b0;
    #1;
    while (csup !== 1'b1 && n < 5) begin
      tick();
      n++;
    end
    chk("vector supply", ~c, vsup);
    chk("resets at supply", 1'b0, crst | vrst | por);
    n = 0;
    while (cclp !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    chk("request at unclamp", 1'b1, req);
    chk("vector clamp", c, vclp);
    n = 0;
    while (req !== 1'b0 && n < 5) begin
      tick();
      n++;
    end
    chk("request drop", 1'b0, req);
    chk("resets at request drop", 1'b0, crst | por);
    n = 0;
    while (st !== CPDS_ON && n < 4) begin
      tick();
      n++;
    end
    chk("on without ack fall", 1'b1, st === CPDS_ON);
    chk("core resets", 1'b1, crst & por);
    chk("vector reset", ~c, vrst);
    chk("vector clamp kept", c, vclp);
    chk("l2 wiped", ~e_l2, wiped[1]);
    chk("l1d wiped", ~e_l1, wiped[0]);
  endtask
  task t_release;
    chk("clamps pending", 1'b0, rel);
    @(posedge i_clk);
    crel <= 1'b1;
    @(posedge i_clk);
    crel <= 1'b0;
    repeat (3) tick();
    chk("released", 1'b1, rel);
    chk("ram clamps", 1'b0, l1c | l2c);
  endtask
  task t_ignored_on;
    @(posedge i_clk);
    pu <= 1'b1;
    @(posedge i_clk);
    pu <= 1'b0;
    repeat (3) tick();
    chk("still on", 1'b1, st === CPDS_ON);
    chk("supply kept", 1'b1, csup & vsup);
  endtask
  initial begin
    repeat (6000) @(posedge i_clk);
    errors++;
    give_verdict();
  end
  initial begin
    {i_clk, i_resetn, pd, pu, co, rl1, rl2, lz, crel, e_l1, e_l2} = 0;
    dly = 4'h1;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    tick();
    t_reset();
    t_down(0, 0, 0, 4'h1);
    t_up(0);
    t_down(1, 1, 0, 4'hc);
    t_up(1);
    t_release();
    t_down(1, 0, 1, 4'h3);
    t_up(0);
    t_release();
    t_down(1, 0, 0, 4'h1);
    t_up(0);
    t_ignored_on();
    give_verdict();
  end
endmodule

//--- verilog/cpds_pkg.sv
package cpds_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // reset hold before the core output clamp rises, in core clock cycles
  localparam int unsigned RESET_HOLD_CYCLES = 8;
  localparam logic [3:0] RESET_HOLD_LAST = 4'(RESET_HOLD_CYCLES - 1);
  // supply settle, a guess: time for a switch to ramp, in ns
  localparam int unsigned SUPPLY_SETTLE_NS = 1000;
  localparam int unsigned SUPPLY_SETTLE_CYCLES =
    (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SUPPLY_SETTLE_LAST = 8'(SUPPLY_SETTLE_CYCLES - 1);
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  typedef enum logic [3:0] {
    CPDS_ON = 4'h0,
    CPDS_REQ_DEBUG = 4'h1,
    CPDS_WAIT_ACK = 4'h2,
    CPDS_HOLD_RESET = 4'h3,
    CPDS_CLAMP = 4'h4,
    CPDS_SUPPLY_OFF = 4'h5,
    CPDS_OFF = 4'h6,
    CPDS_SUPPLY_ON = 4'h7,
    CPDS_UNCLAMP = 4'h8,
    CPDS_RELEASE_DEBUG = 4'h9,
    CPDS_RELEASE_RESET = 4'ha
  } cpds_state_type;
endpackage

//--- verilog/cpds_sequencer.sv
`timescale 1ns/1ps
module cpds_sequencer (
  input wire logic i_clk, // core clock, 25 MHz
  input wire logic i_resetn, // async reset, active low
  input wire logic i_power_down, // pulse: start power-down
  input wire logic i_power_up, // pulse: start power-up from off
  input wire logic i_core_only, // with power-up: leave vector unit off
  input wire logic i_retain_l1d, // keep l1 data cache across cycle
  input wire logic i_retain_l2, // keep l2 cache across cycle
  input wire logic i_l2_zero_size, // l2 configured as zero size
  input wire logic i_cache_clamp_release, // pulse: software asks to free RAM clamps
  input wire logic i_debug_powerdown_acknowledge, // pin from processor
  input wire logic i_trace_powerdown_acknowledge, // pin from processor, unused
  output logic o_debug_powerdown_request, // to processor
  output logic o_trace_powerdown_request, // to processor, tied low
  output logic o_core_reset_n, // core reset, active low
  output logic o_vector_unit_reset_n, // vector unit reset, active low
  output logic o_power_on_reset_n, // power-on reset, active low
  output logic o_core_output_clamp, // core output clamp
  output logic o_vector_unit_output_clamp, // vector unit output clamp
  output logic o_core_supply_on, // core domain supply switch
  output logic o_vector_unit_supply_on, // vector domain supply switch
  output logic o_l1d_reset_inhibit, // l1 data cache reset inhibit
  output logic o_l2_reset_inhibit, // l2 cache reset inhibit
  output logic o_l1d_ram_clamp, // retained l1 data RAM input clamp
  output logic o_l2_ram_clamp, // retained l2 RAM input clamp
  output logic o_cache_clamp_released, // level: RAM clamps are free
  output logic o_busy, // sequence in progress
  output cpds_pkg::cpds_state_type o_state // current step
);
  import cpds_pkg::*;

  cpds_state_type state, next_state;
  logic [7:0] count, next_count;
  logic ack;
  logic vector_off;
  logic l1d_keep, l2_keep;
  logic debug_req, core_rst, vec_rst, por_rst;
  logic core_clamp, vec_clamp, core_sup, vec_sup;
  logic l1d_inh, l2_inh, l1d_clamp, l2_clamp;

  // ack comes from the processor's domain, so it passes two flops first
  cpds_sync u_ack_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(i_debug_powerdown_acknowledge),
    .o_sync(ack)
  );

  wire count_done = (count == COUNT_ZERO);
  // l1d retention only legal with l2 retained or zero-size l2
  wire l1d_allowed = i_retain_l1d && (i_retain_l2 || i_l2_zero_size);
  wire start_down = (state == CPDS_ON) && i_power_down;
  wire start_up = (state == CPDS_OFF) && i_power_up;

  always_comb begin
    next_state = state;
    next_count = (count == COUNT_ZERO) ? COUNT_ZERO : 8'(count - COUNT_ONE);
    unique case (state)
      CPDS_ON: begin
        if (i_power_down) begin
          next_state = CPDS_REQ_DEBUG;
        end
      end
      CPDS_REQ_DEBUG: begin
        // an ack left high by the last cycle must fall before a new request
        if (!ack) begin
          next_state = CPDS_WAIT_ACK;
        end
      end
      CPDS_WAIT_ACK: begin
        if (ack) begin
          next_state = CPDS_HOLD_RESET;
          next_count = 8'(RESET_HOLD_LAST);
        end
      end
      CPDS_HOLD_RESET: begin
        if (count_done) begin
          next_state = CPDS_CLAMP;
        end
      end
      CPDS_CLAMP: begin
        next_state = CPDS_SUPPLY_OFF;
        next_count = SUPPLY_SETTLE_LAST;
      end
      CPDS_SUPPLY_OFF: begin
        if (count_done) begin
          next_state = CPDS_OFF;
        end
      end
      CPDS_OFF: begin
        if (i_power_up) begin
          next_state = CPDS_SUPPLY_ON;
          next_count = SUPPLY_SETTLE_LAST;
        end
      end
      CPDS_SUPPLY_ON: begin
        if (count_done) begin
          next_state = CPDS_UNCLAMP;
        end
      end
      CPDS_UNCLAMP: begin
        next_state = CPDS_RELEASE_DEBUG;
      end
      CPDS_RELEASE_DEBUG: begin
        next_state = CPDS_RELEASE_RESET;
      end
      CPDS_RELEASE_RESET: begin
        next_state = CPDS_ON;
      end
      default: begin
        next_state = CPDS_ON;
      end
    endcase
  end

  // step-wise outputs; every output flop is loaded from next_state, so it changes together with its state
  wire in_down = (state == CPDS_WAIT_ACK) || (state == CPDS_HOLD_RESET) ||
                 (state == CPDS_CLAMP) || (state == CPDS_SUPPLY_OFF) || (state == CPDS_OFF);
  // request waits out a stale ack, and drops one step before the resets release
  wire next_debug_req = (next_state != CPDS_ON) && (next_state != CPDS_REQ_DEBUG) &&
                        (next_state != CPDS_RELEASE_DEBUG) &&
                        (next_state != CPDS_RELEASE_RESET);
  // resets held from ack until release, across every supply change
  wire next_resets_held = (next_state == CPDS_HOLD_RESET) || (next_state == CPDS_CLAMP) ||
                          (next_state == CPDS_SUPPLY_OFF) || (next_state == CPDS_OFF) ||
                          (next_state == CPDS_SUPPLY_ON) || (next_state == CPDS_UNCLAMP) ||
                          (next_state == CPDS_RELEASE_DEBUG);
  wire next_clamps_on = (next_state == CPDS_CLAMP) || (next_state == CPDS_SUPPLY_OFF) ||
                        (next_state == CPDS_OFF) || (next_state == CPDS_SUPPLY_ON);
  wire next_supply_off = (next_state == CPDS_SUPPLY_OFF) || (next_state == CPDS_OFF);
  // vector domain stays off until a full power-up, never switched on unsequenced
  wire next_vector_off = start_up ? i_core_only : vector_off;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= CPDS_ON;
      count <= COUNT_ZERO;
      vector_off <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      vector_off <= next_vector_off;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      debug_req <= 1'b0;
      core_rst <= 1'b0;
      vec_rst <= 1'b0;
      por_rst <= 1'b0;
      core_clamp <= 1'b0;
      vec_clamp <= 1'b0;
      core_sup <= 1'b1;
      vec_sup <= 1'b1;
    end else begin
      debug_req <= next_debug_req;
      core_rst <= next_resets_held;
      // vector reset and clamp stay on after a core-only power-up
      vec_rst <= next_resets_held || next_vector_off;
      por_rst <= next_resets_held;
      core_clamp <= next_clamps_on;
      vec_clamp <= next_clamps_on || (next_vector_off && (next_state != CPDS_ON || vector_off)) ||
                   (next_vector_off && next_state == CPDS_ON);
      core_sup <= !next_supply_off;
      vec_sup <= !next_supply_off && !next_vector_off;
    end
  end

  // cache retention: inhibits latched at power-down start, before any reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      l1d_keep <= 1'b0;
      l2_keep <= 1'b0;
      l1d_inh <= 1'b0;
      l2_inh <= 1'b0;
      l1d_clamp <= 1'b0;
      l2_clamp <= 1'b0;
    end else begin
      if (start_down) begin
        l1d_keep <= l1d_allowed;
        l2_keep <= i_retain_l2 && !i_l2_zero_size;
        l1d_inh <= l1d_allowed;
        l2_inh <= i_retain_l2 && !i_l2_zero_size;
        l1d_clamp <= l1d_allowed;
        l2_clamp <= i_retain_l2 && !i_l2_zero_size;
      end else if ((state == CPDS_ON) && i_cache_clamp_release) begin
        // clamps stay on after power-up until software asks
        l1d_clamp <= 1'b0;
        l2_clamp <= 1'b0;
        l1d_inh <= 1'b0;
        l2_inh <= 1'b0;
        l1d_keep <= 1'b0;
        l2_keep <= 1'b0;
      end
    end
  end

  assign o_debug_powerdown_request = debug_req;
  assign o_trace_powerdown_request = 1'b0;
  assign o_core_reset_n = !core_rst;
  assign o_vector_unit_reset_n = !vec_rst;
  assign o_power_on_reset_n = !por_rst;
  assign o_core_output_clamp = core_clamp;
  assign o_vector_unit_output_clamp = vec_clamp;
  assign o_core_supply_on = core_sup;
  assign o_vector_unit_supply_on = vec_sup;
  assign o_l1d_reset_inhibit = l1d_inh;
  assign o_l2_reset_inhibit = l2_inh;
  assign o_l1d_ram_clamp = l1d_clamp;
  assign o_l2_ram_clamp = l2_clamp;
  assign o_cache_clamp_released = !l1d_clamp && !l2_clamp && !(l1d_keep || l2_keep);
  assign o_busy = (state != CPDS_ON) && (state != CPDS_OFF);
  assign o_state = state;

  a_clamp_after_hold: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(core_clamp) |-> $past(core_rst, RESET_HOLD_CYCLES) &&
      $past(por_rst, RESET_HOLD_CYCLES) && $past(vec_rst, RESET_HOLD_CYCLES))
    else $error("clamp raised before eight-cycle reset hold");
  a_clamp_both: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(core_clamp) |-> vec_clamp && core_sup)
    else $error("clamps not raised together before supply off");
  a_supply_off_clamped: assert property (@(posedge i_clk)
    disable iff (!i_resetn) !core_sup |-> core_clamp && vec_clamp)
    else $error("supply off without both clamps");
  a_reset_in_transition: assert property (@(posedge i_clk)
    disable iff (!i_resetn) ((core_sup != $past(core_sup)) || (vec_sup != $past(vec_sup)))
      |-> core_rst && por_rst && vec_rst)
    else $error("supply changed without resets held");
  a_unclamp_before_debug: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $fell(debug_req) |-> !core_clamp && !$past(core_clamp))
    else $error("debug request dropped with core clamp on");
  a_ack_before_reset: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(core_rst) |-> $past(ack) && debug_req)
    else $error("reset raised before acknowledge");
  a_core_only_vector: assert property (@(posedge i_clk)
    disable iff (!i_resetn) vector_off && (state == CPDS_ON) |-> vec_rst && vec_clamp && !vec_sup)
    else $error("vector unit released in core-only mode");
  a_inhibit_first: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(core_rst) |-> (l2_inh == l2_keep) && $stable(l2_inh))
    else $error("l2 inhibit not set before reset");
  a_trace_low: assert property (@(posedge i_clk)
    disable iff (!i_resetn) !o_trace_powerdown_request)
    else $error("trace request not low");

  // ordering checks for the handshake, the clamps and the vector domain
  a_request_held: assert property (@(posedge i_clk)
    disable iff (!i_resetn) in_down |-> debug_req)
    else $error("debug request low during power-down");
  a_fresh_ack: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(debug_req) |-> !$past(ack))
    else $error("debug request raised while old ack still high");
  a_debug_before_release: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $fell(por_rst) |-> !debug_req && !$past(debug_req))
    else $error("resets released before debug request dropped");
  a_vector_off_safe: assert property (@(posedge i_clk)
    disable iff (!i_resetn) !vec_sup |-> vec_clamp && vec_rst)
    else $error("vector supply off without clamp and reset");
  a_supply_on_reset: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(core_sup) |-> core_rst && por_rst && vec_rst)
    else $error("supply restored without resets held");
  a_inhibit_steady: assert property (@(posedge i_clk)
    disable iff (!i_resetn) (state != CPDS_ON) && ($past(state) != CPDS_ON)
      |-> $stable(l1d_inh) && $stable(l2_inh))
    else $error("reset inhibit changed during a sequence");
  a_hold_resets: assert property (@(posedge i_clk)
    disable iff (!i_resetn) (state == CPDS_HOLD_RESET) |-> core_rst && vec_rst && por_rst)
    else $error("reset not held during hold count");
  a_core_only_unclamp: assert property (@(posedge i_clk)
    disable iff (!i_resetn) (state == CPDS_UNCLAMP) && vector_off
      |-> !core_clamp && vec_clamp && debug_req)
    else $error("core-only unclamp step wrong");
  a_full_unclamp: assert property (@(posedge i_clk)
    disable iff (!i_resetn) (state == CPDS_UNCLAMP) && !vector_off
      |-> !core_clamp && !vec_clamp && debug_req)
    else $error("full power-up unclamp step wrong");
  a_unclamp_after_supply: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $fell(core_clamp) |-> core_sup && $past(core_sup))
    else $error("clamp released before supply restored");
  a_core_only_supply: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(core_sup) && vector_off |-> !vec_sup)
    else $error("vector supply restored in core-only power-up");
  a_clamp_from_hold: assert property (@(posedge i_clk)
    disable iff (!i_resetn) $rose(core_clamp) |-> $past(state) == CPDS_HOLD_RESET)
    else $error("clamp raised outside the hold step");
endmodule

//--- verilog/cpds_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for one pin level
module cpds_sync (
  input wire logic i_clk, // core clock
  input wire logic i_resetn, // async reset, active low
  input wire logic i_async, // pin level from outside
  output logic o_sync // synchronised level
);
  logic meta;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
